// *** hw/eps_pkg.sv ***
// Shared constants and types for the encoder position and speed evaluator
package eps_pkg;
  localparam int EPS_CLK_HZ = 50_000_000;
  localparam int EPS_CLK_MHZ = EPS_CLK_HZ / 1_000_000;
  localparam int EPS_TN_MIN_US = 125;
  localparam int EPS_TN_MAX_US = 250;
  localparam int EPS_TIMEOUT_US = 5000;
  localparam int EPS_TIMEOUT_CYC = EPS_TIMEOUT_US * EPS_CLK_MHZ;
  localparam int EPS_QUAD = 4;
  localparam int EPS_LINES = 1024;
  localparam int EPS_SEC_PER_MIN = 60;
  localparam int EPS_PCT_FULL = 100;
  localparam int EPS_CNT_W = 16;
  localparam int EPS_FINE_W = 12;
  localparam int EPS_HIRES_W = EPS_CNT_W + EPS_FINE_W;
  localparam int EPS_FRAC = 8;
  localparam int EPS_SPD_W = 32;
  localparam int EPS_TS_W = 32;
  localparam int EPS_NUM_W = 48;
  localparam int EPS_DEN_W = 32;
  localparam int EPS_GAIN_W = 16;
  localparam int EPS_PCT_W = 7;
  localparam int EPS_ADC_W = 12;
  localparam int EPS_TN_W = 8;
  localparam int EPS_TNC_W = 14;
  localparam int EPS_K_W = 8;
  localparam int EPS_CX_W = 15;
  localparam int EPS_ITER = 12;
  localparam int EPS_IT_W = 4;
  localparam int EPS_DIV_I_W = 6;
  localparam int EPS_RATIO_W = 9;
  localparam int EPS_FILT_SH = 3;
  // Arctangent of 2^-i, scaled so that a quarter turn equals 2^EPS_FINE_W
  localparam logic [EPS_FINE_W-1:0] EPS_ATAN [EPS_ITER] = '{
    12'h800, 12'h4B9, 12'h27F, 12'h144, 12'h0A3, 12'h051,
    12'h029, 12'h014, 12'h00A, 12'h005, 12'h003, 12'h001};
  localparam logic [EPS_RATIO_W-1:0] EPS_RATIO_ONE = 9'h100;
  localparam logic [EPS_FINE_W-1:0] EPS_FINE_MAX = 12'hFFF;

  typedef logic signed [EPS_CNT_W-1:0] eps_cnt_t;
  typedef logic signed [EPS_HIRES_W-1:0] eps_hires_t;
  typedef logic signed [EPS_SPD_W-1:0] eps_spd_t;
  typedef logic [EPS_GAIN_W-1:0] eps_gain_t;
  typedef enum logic {EPS_SQUARE = 1'b0, EPS_SINCOS = 1'b1} eps_kind_t;
  typedef enum logic {EPS_MODE_COUNT = 1'b0, EPS_MODE_COMBINED = 1'b1} eps_mode_t;
  typedef enum logic [1:0] {EPS_OP_SPD = 2'b00, EPS_OP_RAT = 2'b01, EPS_OP_ZG = 2'b10} eps_op_t;
  typedef enum logic [2:0] {
    EPS_S_IDLE = 3'b000,
    EPS_S_ADC = 3'b001,
    EPS_S_ATAN = 3'b010,
    EPS_S_HIRES = 3'b011,
    EPS_S_DIV = 3'b100,
    EPS_S_OUT = 3'b101
  } eps_state_t;
  typedef struct packed {
    logic a_p;
    logic a_n;
    logic b_p;
    logic b_n;
    logic idx_p;
  } eps_track_t;
  typedef struct packed {
    logic valid;
    logic signed [EPS_ADC_W-1:0] a;
    logic signed [EPS_ADC_W-1:0] b;
  } eps_adc_t;
  typedef struct packed {
    eps_kind_t kind;
    eps_mode_t mode;
    logic single_ended;
    logic [EPS_TN_W-1:0] period_us;
    logic [EPS_PCT_W-1:0] zero_pct;
    eps_gain_t nom_gain;
  } eps_cfg_t;
endpackage : eps_pkg

// *** hw/eps_encoder_eval.sv ***
// Encoder position and speed evaluator: quadrature decode, speed methods, sin/cos fine position
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Direction comes from phase order; track A leading B means clockwise.
// - Every edge of both square tracks makes one count pulse, four per line; edges on both tracks in one sample make no pulse and set track_err.
// - Count pulses drive an up/down counter by decoded direction.
// - Position equals accumulated count in steps of a quarter line.
// - Speed is computed once per sampling period of 125 to 250 us.
// - Pulse counting mode: counts per period give speed, zero when none.
// - Combined mode divides count sum by exact span between edges, scaled to rpm.
// - Combined mode, no count in a period: keep speed, raise period factor k by one.
// - Square encoders: no count for 5 ms forces speed to zero.
// - Square encoders: gain ramps linearly from nominal to settable zero-speed gain at low speed.
// - Actual speed is smoothed by a filter against edge jitter.
// - Single-ended encoders use only the non-inverted tracks.
// - Shaped sin/cos tracks are counted by the same four-fold decoder.
// - Both analogue tracks are converted together; fine angle is atan(B/A).
// - Quadrant correction removes a one-count shift between atan and counter.
// - Counter and fine angle concatenate into one high-resolution position.
// - Sin/cos speed is high-resolution position change per sampling period.
module eps_encoder_eval #(
  parameter int LINES = eps_pkg::EPS_LINES,
  parameter int TIMEOUT_CYC = eps_pkg::EPS_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire eps_pkg::eps_track_t trk,
  input wire eps_pkg::eps_adc_t adc,
  input wire eps_pkg::eps_cfg_t cfg,
  output logic adc_start,
  output logic dir_cw,
  output logic track_err,
  output logic line_fault,
  output eps_pkg::eps_cnt_t position,
  output eps_pkg::eps_cnt_t index_pos,
  output logic index_seen,
  output eps_pkg::eps_hires_t hires_pos,
  output eps_pkg::eps_spd_t speed,
  output eps_pkg::eps_spd_t speed_filt,
  output logic speed_valid,
  output eps_pkg::eps_gain_t gain,
  output logic [eps_pkg::EPS_K_W-1:0] period_factor
);
  import eps_pkg::*;

  // rpm in Q.EPS_FRAC per count per clock cycle of span
  localparam longint RPM_K_L =
    (longint'(EPS_SEC_PER_MIN) * EPS_CLK_HZ * (longint'(1) << EPS_FRAC)) / (EPS_QUAD * LINES);
  localparam logic [EPS_DEN_W-1:0] RPM_K = EPS_DEN_W'(RPM_K_L);
  localparam logic [EPS_DEN_W-1:0] SC_K = RPM_K >> EPS_FINE_W;
  localparam logic [EPS_TS_W-1:0] TIMEOUT_T = EPS_TS_W'(TIMEOUT_CYC);

  // Track front end
  logic a_cur;
  logic b_cur;
  logic a_prev;
  logic b_prev;
  logic idx_prev;

  wire a_ok = cfg.single_ended | (trk.a_p ^ trk.a_n);
  wire b_ok = cfg.single_ended | (trk.b_p ^ trk.b_n);
  wire a_chg = a_cur ^ a_prev;
  wire b_chg = b_cur ^ b_prev;
  wire cnt_pulse = a_chg ^ b_chg;
  wire both_chg = a_chg & b_chg;
  wire up = ~(a_prev ^ b_cur);
  wire signed [1:0] step = cnt_pulse ? (up ? 2'sh1 : -2'sh1) : 2'sh0;
  wire idx_rise = trk.idx_p & ~idx_prev;

  // Square signals from the comparators of a sin/cos encoder arrive on the same pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      a_cur <= 1'b0;
      b_cur <= 1'b0;
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      idx_prev <= 1'b0;
    end else begin
      // A differential pair at equal levels is invalid; hold the last good level
      if (a_ok) begin
        a_cur <= trk.a_p;
      end
      if (b_ok) begin
        b_cur <= trk.b_p;
      end
      a_prev <= a_cur;
      b_prev <= b_cur;
      idx_prev <= trk.idx_p;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      position <= '0;
      dir_cw <= 1'b0;
      track_err <= 1'b0;
      line_fault <= 1'b0;
      index_pos <= '0;
      index_seen <= 1'b0;
    end else begin
      position <= position + step;
      if (cnt_pulse) begin
        dir_cw <= up;
      end
      // Both tracks moving in one sample means a lost count
      track_err <= both_chg;
      line_fault <= ~(a_ok & b_ok);
      if (idx_rise) begin
        index_pos <= position;
        index_seen <= 1'b1;
      end
    end
  end

  // Sampling period and timestamp timer
  logic [EPS_TNC_W-1:0] tick_cnt;
  logic [EPS_TS_W-1:0] ts;
  wire [EPS_TN_W-1:0] tn_us = (cfg.period_us < EPS_TN_W'(EPS_TN_MIN_US)) ? EPS_TN_W'(EPS_TN_MIN_US) :
    (cfg.period_us > EPS_TN_W'(EPS_TN_MAX_US)) ? EPS_TN_W'(EPS_TN_MAX_US) : cfg.period_us;
  wire [EPS_TNC_W-1:0] tn_cyc = EPS_TNC_W'(tn_us * EPS_CLK_MHZ);
  wire tick = (tick_cnt >= tn_cyc - EPS_TNC_W'(1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      ts <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + EPS_TNC_W'(1);
      ts <= ts + EPS_TS_W'(1);
    end
  end

  // Control state
  eps_state_t state;
  eps_op_t op;
  eps_cnt_t acc;
  eps_cnt_t cnt_snap;
  logic [EPS_TS_W-1:0] last_ts;
  logic [EPS_TS_W-1:0] ref_ts;
  logic [EPS_CNT_W-1:0] meas_mag;
  logic [EPS_DEN_W-1:0] meas_span;
  logic [EPS_NUM_W-1:0] num_q;
  logic [EPS_DEN_W-1:0] den;
  logic [EPS_DEN_W:0] rem;
  logic [EPS_DIV_I_W-1:0] div_i;
  logic neg;
  logic [EPS_RATIO_W-1:0] ratio;
  eps_gain_t zgain;
  logic signed [EPS_CX_W-1:0] cx;
  logic signed [EPS_CX_W-1:0] cy;
  logic signed [EPS_CX_W-1:0] cz;
  logic [EPS_IT_W-1:0] it;
  logic [1:0] qa;

  wire idle = (state == EPS_S_IDLE);
  wire square = (cfg.kind == EPS_SQUARE);
  wire combined = (cfg.mode == EPS_MODE_COMBINED);
  wire have_cnt = (acc != '0);
  wire [EPS_TS_W-1:0] span_now = last_ts - ref_ts;
  wire [EPS_TS_W-1:0] idle_time = ts - ref_ts;
  wire timed_out = (idle_time >= TIMEOUT_T);
  wire consume = tick & idle & square & (~combined | have_cnt);
  wire [EPS_CNT_W-1:0] acc_mag = acc[EPS_CNT_W-1] ? EPS_CNT_W'(-acc) : EPS_CNT_W'(acc);

  // Count sum and last-edge time since the reference edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= '0;
      last_ts <= '0;
    end else begin
      // An edge in the consuming cycle starts the next sum instead of being lost
      acc <= consume ? eps_cnt_t'(step) : acc + step;
      if (cnt_pulse) begin
        last_ts <= ts;
      end
    end
  end

  // Divider datapath, one quotient bit per cycle
  wire [EPS_DEN_W:0] rem_sh = {rem[EPS_DEN_W-1:0], num_q[EPS_NUM_W-1]};
  wire fits = (rem_sh >= {1'b0, den});
  wire [EPS_DEN_W:0] rem_nx = fits ? rem_sh - {1'b0, den} : rem_sh;
  wire div_done = (div_i == EPS_DIV_I_W'(EPS_NUM_W));
  wire q_big = |num_q[EPS_NUM_W-1:EPS_SPD_W-1];
  wire [EPS_SPD_W-1:0] q_sat = q_big ? {1'b0, {(EPS_SPD_W-1){1'b1}}} : num_q[EPS_SPD_W-1:0];
  wire eps_spd_t spd_res = neg ? eps_spd_t'(-q_sat) : eps_spd_t'(q_sat);
  wire [EPS_RATIO_W-1:0] ratio_res =
    (num_q >= EPS_NUM_W'(EPS_RATIO_ONE)) ? EPS_RATIO_ONE : num_q[EPS_RATIO_W-1:0];

  // Divider operands for each kind of job
  wire [EPS_PCT_W-1:0] pct_c = (cfg.zero_pct > EPS_PCT_W'(EPS_PCT_FULL)) ?
    EPS_PCT_W'(EPS_PCT_FULL) : cfg.zero_pct;
  wire [EPS_NUM_W-1:0] num_cnt = EPS_NUM_W'(acc_mag) * EPS_NUM_W'(RPM_K);
  wire [EPS_NUM_W-1:0] num_rat = EPS_NUM_W'({meas_mag, {EPS_FRAC{1'b0}}}) * EPS_NUM_W'(tn_cyc);
  wire [EPS_NUM_W-1:0] num_zg = EPS_NUM_W'(cfg.nom_gain) * EPS_NUM_W'(pct_c);

  // Arctangent vectoring on magnitudes keeps the angle inside one quadrant
  wire signed [EPS_CX_W-1:0] xs = cx >>> it;
  wire signed [EPS_CX_W-1:0] ys = cy >>> it;
  wire y_pos = ~cy[EPS_CX_W-1];
  wire atan_done = (it == EPS_IT_W'(EPS_ITER));
  wire [EPS_ADC_W-1:0] mag_a = adc.a[EPS_ADC_W-1] ? EPS_ADC_W'(-adc.a) : EPS_ADC_W'(adc.a);
  wire [EPS_ADC_W-1:0] mag_b = adc.b[EPS_ADC_W-1] ? EPS_ADC_W'(-adc.b) : EPS_ADC_W'(adc.b);
  wire sa = adc.a[EPS_ADC_W-1];
  wire sb = adc.b[EPS_ADC_W-1];
  wire [1:0] q_adc = {sa, sa ^ ~sb};
  wire [EPS_FINE_W-1:0] fz = cz[EPS_CX_W-1] ? '0 :
    (cz > EPS_CX_W'(EPS_FINE_MAX)) ? EPS_FINE_MAX : cz[EPS_FINE_W-1:0];
  // Even quadrants run the atan backwards as the shaft turns
  wire [EPS_FINE_W-1:0] fine = qa[0] ? fz : ~fz;
  wire [1:0] qd = qa - cnt_snap[1:0];
  wire eps_cnt_t corr_cnt = (qd == 2'h1) ? cnt_snap + eps_cnt_t'(1) :
    (qd == 2'h3) ? cnt_snap - eps_cnt_t'(1) : cnt_snap;
  wire eps_hires_t hires_nx = {corr_cnt, fine};
  wire eps_hires_t delta = hires_nx - hires_pos;
  wire [EPS_HIRES_W-1:0] d_mag = delta[EPS_HIRES_W-1] ? EPS_HIRES_W'(-delta) : EPS_HIRES_W'(delta);
  wire [EPS_NUM_W-1:0] num_sc = EPS_NUM_W'(d_mag) * EPS_NUM_W'(SC_K);

  // Filter and gain ramp
  wire eps_spd_t filt_nx = speed_filt + ((speed - speed_filt) >>> EPS_FILT_SH);
  wire eps_gain_t g_diff = cfg.nom_gain - zgain;
  wire [EPS_GAIN_W+EPS_RATIO_W-1:0] g_prod = g_diff * ratio;
  wire eps_gain_t g_ramp = zgain + EPS_GAIN_W'(g_prod >> EPS_FRAC);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= EPS_S_IDLE;
      op <= EPS_OP_SPD;
      cnt_snap <= '0;
      ref_ts <= '0;
      meas_mag <= '0;
      meas_span <= '0;
      num_q <= '0;
      den <= '0;
      rem <= '0;
      div_i <= '0;
      neg <= 1'b0;
      ratio <= '0;
      zgain <= '0;
      cx <= '0;
      cy <= '0;
      cz <= '0;
      it <= '0;
      qa <= '0;
      adc_start <= 1'b0;
      hires_pos <= '0;
      speed <= '0;
      speed_filt <= '0;
      speed_valid <= 1'b0;
      gain <= '0;
      period_factor <= '0;
    end else begin
      adc_start <= 1'b0;
      speed_valid <= 1'b0;
      unique case (state)
        EPS_S_IDLE: begin
          if (tick && !square) begin
            // Sample both converters on the same strobe as the counter snapshot
            adc_start <= 1'b1;
            cnt_snap <= position;
            state <= EPS_S_ADC;
          end else if (consume) begin
            meas_mag <= acc_mag;
            meas_span <= combined ? span_now : EPS_DEN_W'(tn_cyc);
            num_q <= num_cnt;
            den <= combined ? span_now : EPS_DEN_W'(tn_cyc);
            neg <= acc[EPS_CNT_W-1];
            rem <= '0;
            div_i <= '0;
            op <= EPS_OP_SPD;
            ref_ts <= last_ts;
            period_factor <= '0;
            state <= EPS_S_DIV;
          end else if (tick && square && timed_out) begin
            speed <= '0;
            ratio <= '0;
            ref_ts <= ts;
            period_factor <= '0;
            num_q <= num_zg;
            den <= EPS_DEN_W'(EPS_PCT_FULL);
            neg <= 1'b0;
            rem <= '0;
            div_i <= '0;
            op <= EPS_OP_ZG;
            state <= EPS_S_DIV;
          end else if (tick && square) begin
            period_factor <= period_factor + EPS_K_W'(1);
          end
        end
        EPS_S_ADC: begin
          if (adc.valid) begin
            cx <= EPS_CX_W'(mag_a);
            cy <= EPS_CX_W'(mag_b);
            cz <= '0;
            it <= '0;
            qa <= q_adc;
            state <= EPS_S_ATAN;
          end
        end
        EPS_S_ATAN: begin
          if (atan_done) begin
            state <= EPS_S_HIRES;
          end else begin
            cx <= y_pos ? cx + ys : cx - ys;
            cy <= y_pos ? cy - xs : cy + xs;
            cz <= y_pos ? cz + EPS_CX_W'(EPS_ATAN[it]) : cz - EPS_CX_W'(EPS_ATAN[it]);
            it <= it + EPS_IT_W'(1);
          end
        end
        EPS_S_HIRES: begin
          hires_pos <= hires_nx;
          num_q <= num_sc;
          den <= EPS_DEN_W'(tn_cyc);
          neg <= delta[EPS_HIRES_W-1];
          rem <= '0;
          div_i <= '0;
          op <= EPS_OP_SPD;
          state <= EPS_S_DIV;
        end
        EPS_S_DIV: begin
          if (!div_done) begin
            rem <= rem_nx;
            num_q <= {num_q[EPS_NUM_W-2:0], fits};
            div_i <= div_i + EPS_DIV_I_W'(1);
          end else begin
            rem <= '0;
            div_i <= '0;
            neg <= 1'b0;
            unique case (op)
              EPS_OP_SPD: begin
                speed <= spd_res;
                if (!square) begin
                  // Fine position always moves, so the full gain applies
                  ratio <= EPS_RATIO_ONE;
                  state <= EPS_S_OUT;
                end else begin
                  num_q <= num_rat;
                  den <= meas_span;
                  op <= EPS_OP_RAT;
                end
              end
              EPS_OP_RAT: begin
                // Counts per period in Q.EPS_FRAC; one count per period is full gain
                ratio <= ratio_res;
                num_q <= num_zg;
                den <= EPS_DEN_W'(EPS_PCT_FULL);
                op <= EPS_OP_ZG;
              end
              EPS_OP_ZG: begin
                zgain <= num_q[EPS_GAIN_W-1:0];
                state <= EPS_S_OUT;
              end
              default: begin
                state <= EPS_S_IDLE;
              end
            endcase
          end
        end
        EPS_S_OUT: begin
          speed_filt <= filt_nx;
          gain <= (ratio >= EPS_RATIO_ONE) ? cfg.nom_gain : g_ramp;
          speed_valid <= 1'b1;
          state <= EPS_S_IDLE;
        end
        default: begin
          state <= EPS_S_IDLE;
        end
      endcase
    end
  end
endmodule : eps_encoder_eval

`default_nettype wire

// *** verif/eps_encoder_eval_asserts.sv ***
// Port-level assertions for the encoder position and speed evaluator
`timescale 1ns/1ps
`default_nettype none
module eps_encoder_eval_asserts #(
  parameter int LINES = eps_pkg::EPS_LINES,
  parameter int TIMEOUT_CYC = eps_pkg::EPS_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire eps_pkg::eps_track_t trk,
  input wire eps_pkg::eps_cfg_t cfg,
  input wire logic adc_start,
  input wire logic dir_cw,
  input wire logic track_err,
  input wire logic line_fault,
  input wire eps_pkg::eps_cnt_t position,
  input wire logic index_seen,
  input wire eps_pkg::eps_spd_t speed,
  input wire eps_pkg::eps_spd_t speed_filt,
  input wire logic speed_valid,
  input wire eps_pkg::eps_gain_t gain,
  input wire logic [eps_pkg::EPS_K_W-1:0] period_factor
);
  import eps_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  eps_track_t trk_q;
  eps_cnt_t pos_ref;
  logic [15:0] since_sv;
  logic sv_seen;
  wire logic pair_ok = cfg.single_ended || (trk.a_p != trk.a_n && trk.b_p != trk.b_n);
  wire logic a_chg = trk.a_p != trk_q.a_p;
  wire logic b_chg = trk.b_p != trk_q.b_p;
  wire logic one_chg = pair_ok && (a_chg ^ b_chg);
  wire logic both_chg = pair_ok && a_chg && b_chg;
  // Forward order 00,10,11,01: after an A change, A differs from B
  wire logic fwd = one_chg && (a_chg ? trk.a_p != trk.b_p : trk.a_p == trk.b_p);
  wire logic rev = one_chg && !fwd;
  wire logic [7:0] pus = cfg.period_us < 8'h7D ? 8'h7D : (cfg.period_us > 8'hFA ? 8'hFA : cfg.period_us);
  wire logic [15:0] tn_cyc = 16'(pus) * 16'(EPS_CLK_MHZ);
  always_ff @(posedge clk) begin
    trk_q <= trk;
    if (fwd || rev) pos_ref <= position;
    since_sv <= (!rst_n || speed_valid) ? 16'h0 : since_sv + 16'h1;
    sv_seen <= rst_n && (sv_seen || speed_valid);
  end
  sequence s_fwd;
    fwd;
  endsequence
  sequence s_rev;
    rev;
  endsequence
  a_fwd_count: assert property (s_fwd |-> ##[1:4] (position - pos_ref == 16'sh1) && dir_cw)
    else $error("forward edge not counted up");
  a_rev_count: assert property (s_rev |-> ##[1:4] (pos_ref - position == 16'sh1) && !dir_cw)
    else $error("reverse edge not counted down");
  a_lost_count: assert property (both_chg |-> ##[1:4] track_err)
    else $error("double track change not flagged");
  a_pair_fault: assert property (!cfg.single_ended && trk.a_p == trk.a_n |-> ##[1:4] line_fault)
    else $error("equal differential pair not flagged");
  a_se_no_fault: assert property (cfg.single_ended |-> !line_fault)
    else $error("line fault raised in single-ended mode");
  a_period_exact: assert property (speed_valid && sv_seen && cfg.kind == EPS_SQUARE
      && cfg.mode == EPS_MODE_COUNT |-> since_sv == tn_cyc - 16'h1)
    else $error("speed update spacing differs from sampling period");
  a_valid_pulse: assert property (speed_valid |=> !speed_valid)
    else $error("speed valid longer than one cycle");
  a_filter_step: assert property (speed_valid |->
      speed_filt == $past(speed_filt) + ((speed - $past(speed_filt)) >>> 3))
    else $error("filtered speed step wrong");
  a_k_hold: assert property (cfg.mode == EPS_MODE_COMBINED && $changed(period_factor)
      && period_factor != 8'h0 |-> period_factor == $past(period_factor) + 8'h1 && $stable(speed))
    else $error("period factor step or speed hold wrong");
  a_sincos_gain: assert property (speed_valid && cfg.kind == EPS_SINCOS |-> gain == cfg.nom_gain)
    else $error("sincos gain not nominal");
  a_idx_sticky: assert property (index_seen |=> index_seen)
    else $error("index seen dropped");
  a_square_quiet: assert property (cfg.kind == EPS_SQUARE |-> !adc_start)
    else $error("converter started for square encoder");
  a_reset_clear: assert property ($rose(rst_n) |-> position == 16'sh0 && speed == 32'sh0)
    else $error("outputs not cleared by reset");
endmodule : eps_encoder_eval_asserts
bind eps_encoder_eval eps_encoder_eval_asserts #(.LINES(LINES), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .trk(trk), .cfg(cfg), .adc_start(adc_start), .dir_cw(dir_cw),
  .track_err(track_err), .line_fault(line_fault), .position(position), .index_seen(index_seen),
  .speed(speed), .speed_filt(speed_filt), .speed_valid(speed_valid), .gain(gain),
  .period_factor(period_factor));
`default_nettype wire

// *** verif/eps_encoder_model.sv ***
// Behavioural square and sine/cosine encoder driving the evaluator pins
`timescale 1ns/1ps
`default_nettype none
module eps_encoder_model #(
  parameter int PPR = 64
) (
  input wire logic clk,
  input wire logic step_fwd,
  input wire logic step_rev,
  input wire logic jump,
  input wire logic pair_short,
  input wire logic adc_skew,
  input wire logic adc_start,
  output wire eps_pkg::eps_track_t trk,
  output wire eps_pkg::eps_adc_t adc
);
  import eps_pkg::*;
  logic [15:0] ph = 16'h0;
  logic [1:0] aq = 2'h0;
  logic [4:0] dly = 5'h0;
  // Forward phases 00,10,11,01: A leads B by a quarter period
  wire logic a_lvl = ph[1:0] == 2'h1 || ph[1:0] == 2'h2;
  always @(posedge clk) begin
    if (step_fwd) ph <= ph + 16'h1;
    else if (step_rev) ph <= ph - 16'h1;
    else if (jump) ph <= ph + 16'h2;
    // Both tracks frozen at one instant; skew fakes a propagation shift
    if (adc_start) aq <= ph[1:0] + {1'b0, adc_skew};
    dly <= adc_start ? 5'h14 : (dly != 5'h0 ? dly - 5'h1 : 5'h0);
  end
  assign trk.a_p = a_lvl;
  assign trk.b_p = ph[1];
  assign trk.a_n = pair_short ? a_lvl : !a_lvl;
  assign trk.b_n = pair_short ? ph[1] : !ph[1];
  assign trk.idx_p = (int'(ph) % PPR) == PPR / 2;
  assign adc.valid = dly == 5'h1;
  // Outside the valid cycle the result bus shows the complement, not a held value
  assign adc.a = {12{!adc.valid}} ^ (aq[1] ? 12'hC00 : 12'h400);
  assign adc.b = {12{!adc.valid}} ^ (aq[1] == aq[0] ? 12'hC00 : 12'h400);
endmodule : eps_encoder_model
`default_nettype wire

// *** verif/eps_encoder_eval_tb.sv ***
// Self-checking bench for the encoder position and speed evaluator
`timescale 1ns/1ps
`default_nettype none
module eps_encoder_eval_tb;
  import eps_pkg::*;
  localparam int TMO = 20000;
  localparam int PPR = 64;
  localparam longint RPMK = longint'(EPS_SEC_PER_MIN) * EPS_CLK_HZ * 256 / (EPS_QUAD * EPS_LINES);
  localparam longint TN = longint'(EPS_TN_MIN_US) * EPS_CLK_MHZ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic step_fwd = 1'b0;
  logic step_rev = 1'b0;
  logic jump = 1'b0;
  logic pair_short = 1'b0;
  logic adc_skew = 1'b0;
  logic err;
  eps_cfg_t cfg = '0;
  eps_track_t trk;
  eps_adc_t adc;
  logic adc_start, dir_cw, track_err, line_fault, index_seen, speed_valid;
  eps_cnt_t position, index_pos, p0;
  eps_hires_t hires_pos;
  eps_spd_t speed, speed_filt, s_held;
  eps_gain_t gain;
  logic [EPS_K_W-1:0] period_factor;
  longint cyc = 0;
  longint c1, c2;
  int errors = 0;
  int tests_run = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  eps_encoder_model #(.PPR(PPR)) enc (.clk(clk), .step_fwd(step_fwd), .step_rev(step_rev),
    .jump(jump), .pair_short(pair_short), .adc_skew(adc_skew), .adc_start(adc_start),
    .trk(trk), .adc(adc));
  eps_encoder_eval #(.TIMEOUT_CYC(TMO)) DUT (.clk(clk), .rst_n(rst_n), .trk(trk), .adc(adc),
    .cfg(cfg), .adc_start(adc_start), .dir_cw(dir_cw), .track_err(track_err),
    .line_fault(line_fault), .position(position), .index_pos(index_pos),
    .index_seen(index_seen), .hires_pos(hires_pos), .speed(speed), .speed_filt(speed_filt),
    .speed_valid(speed_valid), .gain(gain), .period_factor(period_factor));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic steps(input int n, input logic f);
    for (int i = 0; i < n; i++) begin
      step_fwd <= f;
      step_rev <= !f;
      @(posedge clk);
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
      c2 = cyc;
      repeat (3) @(posedge clk);
    end
  endtask : steps
  task automatic wait_valid;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (speed_valid !== 1'b1 && n < 15000);
    if (speed_valid !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask : wait_valid
  // Park the encoder at phase 00 so release brings no stray count
  task automatic do_reset(input eps_kind_t k, input eps_mode_t m, input logic se);
    for (int i = 0; i < 4 && (trk.a_p || trk.b_p); i++) steps(1, 1'b1);
    cfg <= '{kind: k, mode: m, single_ended: se, period_us: 8'h7D, zero_pct: 7'h28,
      nom_gain: 16'h1000};
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task automatic t_count;
    do_reset(EPS_SQUARE, EPS_MODE_COUNT, 1'b0);
    wait_valid();
    check(speed, 32'h0);
    check(gain, 16'h0666);
    p0 = position;
    steps(10, 1'b1);
    wait_valid();
    check(speed, 32'(10 * RPMK / TN));
    check(speed_filt, 32'(10 * RPMK / TN / 8));
    check(gain, 16'h1000);
    check(position - p0, 32'hA);
    check(dir_cw, 1'b1);
    $display("test count done");
  endtask : t_count
  task automatic t_faults;
    p0 = position;
    steps(3, 1'b0);
    check(position - p0, 32'hFFFFFFFD);
    check(dir_cw, 1'b0);
    p0 = position;
    err = 1'b0;
    jump <= 1'b1;
    @(posedge clk);
    jump <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      err = err | track_err;
    end
    check(err, 1'b1);
    pair_short <= 1'b1;
    repeat (6) @(posedge clk);
    check(line_fault, 1'b1);
    pair_short <= 1'b0;
    repeat (6) @(posedge clk);
    check(line_fault, 1'b0);
    check(position - p0, 32'h0);
    // Index rises when the encoder phase reaches half a turn; capture lags one count
    p0 = position;
    c1 = (95 - enc.ph % 64) % 64;
    steps(PPR, 1'b1);
    check(index_seen, 1'b1);
    check(index_pos, 32'(p0 + c1));
    $display("test faults done");
  endtask : t_faults
  task automatic t_single;
    do_reset(EPS_SQUARE, EPS_MODE_COUNT, 1'b1);
    pair_short <= 1'b1;
    p0 = position;
    steps(5, 1'b1);
    check(position - p0, 32'h5);
    check(line_fault, 1'b0);
    pair_short <= 1'b0;
    $display("test single done");
  endtask : t_single
  task automatic t_combined;
    do_reset(EPS_SQUARE, EPS_MODE_COMBINED, 1'b0);
    steps(1, 1'b1);
    c1 = c2;
    wait_valid();
    steps(8, 1'b1);
    wait_valid();
    check(speed, 32'(8 * RPMK / (c2 - c1)));
    check(period_factor, 8'h0);
    s_held = speed;
    repeat (2 * TN) @(posedge clk);
    check(period_factor, 8'h2);
    check(speed, s_held);
    wait_valid();
    check(speed, 32'h0);
    check(gain, 16'h0666);
    $display("test combined done");
  endtask : t_combined
  task automatic t_sincos;
    do_reset(EPS_SINCOS, EPS_MODE_COUNT, 1'b0);
    wait_valid();
    wait_valid();
    check(speed, 32'h0);
    check(eps_cnt_t'(hires_pos[EPS_HIRES_W-1:EPS_FINE_W]), position);
    check(gain, 16'h1000);
    steps(4, 1'b1);
    wait_valid();
    check(speed, 32'(4 * 4096 * (RPMK >> 12) / TN));
    adc_skew <= 1'b1;
    wait_valid();
    check(eps_cnt_t'(hires_pos[EPS_HIRES_W-1:EPS_FINE_W]), position + 16'sh1);
    adc_skew <= 1'b0;
    $display("test sincos done");
  endtask : t_sincos
  initial begin
    @(posedge clk);
    t_count();
    t_faults();
    t_single();
    t_combined();
    t_sincos();
    conclude();
  end
endmodule : eps_encoder_eval_tb
`default_nettype wire
